// [hw/msp_pkg.sv]
package msp_pkg;

    localparam int REC_W        = 32;
    localparam int NUM_RECORDS  = 8;
    localparam int GROUP_W      = 4;
    localparam int CFG_BITS     = 112;
    localparam int MODE_BITS    = 7;
    localparam int CMD_W        = 8;
    localparam int ADDR_W       = 7;
    localparam int BITCNT_W     = 9;
    localparam int AXI_ADDR_W   = 6;

    // Command address map
    localparam logic [6:0] CFG_LIMIT      = 7'h70;
    localparam logic [6:0] CFG_LOCK_ADDR  = 7'h00;
    localparam logic [6:0] CFG_CHK_ADDR   = 7'h6F;
    localparam logic [6:0] TEST_LATCH_LO  = 7'h70;
    localparam logic [6:0] TEST_LATCH_HI  = 7'h73;
    localparam logic [6:0] MODE_BASE      = 7'h78;
    localparam logic [6:0] MODE_LAST      = 7'h7E;
    localparam logic [6:0] ADVANCE_ADDR   = 7'h7F;

    // Positions inside the mode vector (address minus MODE_BASE)
    localparam int MODE_PUMP = 1;
    localparam int MODE_RD   = 5;
    localparam int MODE_WE   = 6;

    // Configuration bit positions used by the port itself
    localparam int CFG_LOCK_BIT   = 0;
    localparam int CFG_BITORD_BIT = 1;
    localparam int CFG_POL_BIT    = 2;

    // AXI4-Lite byte offsets
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_CFG0   = 6'h08;
    localparam logic [5:0] OFS_CFG1   = 6'h0C;
    localparam logic [5:0] OFS_CFG2   = 6'h10;
    localparam logic [5:0] OFS_CFG3   = 6'h14;
    localparam logic [5:0] OFS_MODE   = 6'h18;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic       CTRL_ENABLE_RST = 1'h1;

    typedef struct packed {
        logic select_n;
        logic sync_dir;
        logic sclk;
        logic sdata;
    } pins_t;

endpackage

// [hw/pin_sync2.sv]
`timescale 1ns/1ps
module pin_sync2 (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire msp_pkg::pins_t pins_in,
    output msp_pkg::pins_t    pins_out
);
    msp_pkg::pins_t meta_reg;

    // Reset to idle: every pin idles high on its pull-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '1;
            pins_out <= '1;
        end else begin
            meta_reg <= pins_in;
            pins_out <= meta_reg;
        end
    end
endmodule

// [hw/meter_serial_host_port.sv]
`timescale 1ns/1ps
module meter_serial_host_port #(
    parameter int NUM_RECORDS = msp_pkg::NUM_RECORDS,
    parameter int REC_W       = msp_pkg::REC_W,
    parameter int GROUP_W     = msp_pkg::GROUP_W
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [msp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [msp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          port_select_n,
    input  wire logic                          sync_direction,
    input  wire logic                          serial_clock_pin,
    input  wire logic                          serial_data_pin_i,
    output logic                               serial_data_pin_o,
    output logic                               serial_data_pin_oe,
    input  wire logic [NUM_RECORDS*REC_W-1:0]  records_in,
    output logic [GROUP_W-1:0]                 group_ptr_reg,
    output logic [msp_pkg::CFG_BITS-1:0]       config_eff_reg,
    output logic [msp_pkg::MODE_BITS-1:0]      mode_reg
);
    localparam int DATA_W = REC_W - 4;

    msp_pkg::pins_t pins_raw;
    msp_pkg::pins_t pins_s;
    msp_pkg::pins_t pins_prev_reg;

    assign pins_raw = '{select_n: port_select_n, sync_dir: sync_direction,
                        sclk: serial_clock_pin, sdata: serial_data_pin_i};

    pin_sync2 u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pins_in  (pins_raw),
        .pins_out (pins_s)
    );

    logic                           ctrl_enable_reg;
    logic                           soft_latch_reg;
    logic [msp_pkg::CFG_BITS-1:0]   shadow_reg;
    logic [msp_pkg::CFG_BITS-1:0]   otp_reg;
    logic                           lock_eff_reg;
    logic [msp_pkg::BITCNT_W-1:0]   bit_cnt_reg;
    logic [2:0]                     wr_cnt_reg;
    logic [6:0]                     shift_reg;
    logic [REC_W-1:0]               latch_mem [NUM_RECORDS];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_prev_reg <= '1;
        end else begin
            pins_prev_reg <= pins_s;
        end
    end

    // Pin decoding
    wire pol        = config_eff_reg[msp_pkg::CFG_POL_BIT];
    wire lsb_first  = config_eff_reg[msp_pkg::CFG_BITORD_BIT];
    wire active     = ctrl_enable_reg & ~pins_s.select_n;
    wire was_active = ~pins_prev_reg.select_n;
    wire read_mode  = active & pins_s.sync_dir;
    wire write_mode = active & ~pins_s.sync_dir;
    wire sync_rise  = pins_s.sync_dir & ~pins_prev_reg.sync_dir;
    wire lead_edge  = (pins_prev_reg.sclk != pol) & (pins_s.sclk == pol);
    wire trail_edge = (pins_prev_reg.sclk == pol) & (pins_s.sclk != pol);
    wire idle_latch = ctrl_enable_reg & pins_s.select_n & sync_rise;

    // Command decode on the final bit's leading edge
    wire       exec      = write_mode & was_active & lead_edge & (wr_cnt_reg == 3'h7);
    wire [7:0] cmd       = {shift_reg, pins_s.sdata};
    wire       cmd_data  = cmd[7];
    wire [6:0] cmd_addr  = cmd[6:0];
    wire       is_cfg    = cmd_addr < msp_pkg::CFG_LIMIT;
    wire       is_test   = (cmd_addr >= msp_pkg::TEST_LATCH_LO) &
                           (cmd_addr <= msp_pkg::TEST_LATCH_HI);
    wire       is_mode   = (cmd_addr >= msp_pkg::MODE_BASE) &
                           (cmd_addr <= msp_pkg::MODE_LAST);
    wire       is_adv    = cmd_addr == msp_pkg::ADVANCE_ADDR;
    wire       allow     = ~lock_eff_reg | is_adv | is_test;
    wire       cfg_wr    = exec & allow & is_cfg;
    wire       mode_wr   = exec & allow & is_mode;
    wire       adv_wr    = exec & is_adv;
    wire       test_lat  = exec & is_test & cmd_data;
    wire [2:0] mode_idx  = 3'(cmd_addr - msp_pkg::MODE_BASE);
    wire       latch_now = idle_latch | test_lat | soft_latch_reg;

    // Shifting position: record, byte, bit
    wire                  shift_done = bit_cnt_reg[msp_pkg::BITCNT_W-1];
    wire [2:0]            rec_sel    = bit_cnt_reg[7:5];
    wire [1:0]            byte_sel   = bit_cnt_reg[4:3];
    wire [2:0]            bit_sel    = bit_cnt_reg[2:0];
    wire [REC_W-1:0]      cur_word   = latch_mem[rec_sel];
    wire [7:0]            cur_byte   = cur_word[byte_sel*8 +: 8];
    wire [2:0]            bit_pos    = lsb_first ? bit_sel : 3'h7 - bit_sel;
    wire                  out_bit    = shift_done | cur_byte[bit_pos];

    // Record latching, one entry per record
    function automatic logic [3:0] parity_nibble(input logic [DATA_W-1:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int n = 0; n < DATA_W / 4; n++) begin
            p = p ^ d[n*4 +: 4];
        end
        return p;
    endfunction

    for (genvar i = 0; i < NUM_RECORDS; i++) begin : g_rec
        wire [DATA_W-1:0] src =
            (i == NUM_RECORDS - 2) ? config_eff_reg[DATA_W-1:0] :
            (i == NUM_RECORDS - 1) ? config_eff_reg[2*DATA_W-1:DATA_W] :
            records_in[i*REC_W +: DATA_W];
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                latch_mem[i] <= '0;
            end else if (latch_now) begin
                latch_mem[i] <= {parity_nibble(src), src};
            end
        end
    end

    // Bit counter: cleared while idle or by a sync pulse once selected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt_reg <= '0;
        end else if (!active || !was_active || sync_rise) begin
            bit_cnt_reg <= '0;
        end else if (read_mode && trail_edge && !shift_done) begin
            bit_cnt_reg <= bit_cnt_reg + 9'h001;
        end
    end

    // Command shifter; back-to-back commands in one select period
    always_ff @(posedge aclk) begin
        if (!aresetn || !write_mode) begin
            wr_cnt_reg <= '0;
            shift_reg  <= '0;
        end else if (lead_edge && was_active) begin
            wr_cnt_reg <= wr_cnt_reg + 3'h1;
            shift_reg  <= cmd[6:0];
        end
    end

    // Data driver: registered, off in write mode and when idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_data_pin_o  <= 1'b1;
            serial_data_pin_oe <= 1'b0;
        end else begin
            serial_data_pin_oe <= read_mode;
            serial_data_pin_o  <= out_bit;
        end
    end

    // Shadow and permanent cells; antifuse cells can only be set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_reg <= '0;
            otp_reg    <= '0;
        end else if (cfg_wr) begin
            shadow_reg[cmd_addr] <= cmd_data;
            if (mode_reg[msp_pkg::MODE_WE] && cmd_data) begin
                otp_reg[cmd_addr] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg      <= '0;
            group_ptr_reg <= '0;
        end else begin
            if (mode_wr) begin
                mode_reg[mode_idx] <= cmd_data;
            end
            if (adv_wr) begin
                group_ptr_reg <= group_ptr_reg + 1'b1;
            end
        end
    end

    // Read disable clear selects the permanent cells
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_eff_reg <= '0;
            lock_eff_reg   <= 1'b0;
        end else begin
            config_eff_reg <= mode_reg[msp_pkg::MODE_RD] ? shadow_reg : otp_reg;
            if (!active) begin
                lock_eff_reg <= config_eff_reg[msp_pkg::CFG_LOCK_BIT];
            end
        end
    end

    // AXI4-Lite slave
    logic                          aw_got_reg;
    logic                          w_got_reg;
    logic [msp_pkg::AXI_ADDR_W-1:0] awaddr_reg;
    logic [31:0]                   wdata_reg;
    logic [3:0]                    wstrb_reg;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire wr_ctrl  = awaddr_reg == msp_pkg::OFS_CTRL;
    wire wr_ok    = wr_ctrl | (awaddr_reg == msp_pkg::OFS_STATUS) |
                    ((awaddr_reg >= msp_pkg::OFS_CFG0) & (awaddr_reg <= msp_pkg::OFS_MODE) &
                     (awaddr_reg[1:0] == 2'h0));
    wire ar_take  = s_axi_arvalid & s_axi_arready;

    wire [31:0] status_word = {12'h000, lock_eff_reg, mode_reg[msp_pkg::MODE_WE],
                               mode_reg[msp_pkg::MODE_RD], 1'b0, group_ptr_reg,
                               7'h00, active, 4'h0} | {23'h000000, bit_cnt_reg};

    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            msp_pkg::OFS_CTRL:   rd_word = {31'h00000000, ctrl_enable_reg};
            msp_pkg::OFS_STATUS: rd_word = status_word;
            msp_pkg::OFS_CFG0:   rd_word = config_eff_reg[31:0];
            msp_pkg::OFS_CFG1:   rd_word = config_eff_reg[63:32];
            msp_pkg::OFS_CFG2:   rd_word = config_eff_reg[95:64];
            msp_pkg::OFS_CFG3:   rd_word = {16'h0000, config_eff_reg[111:96]};
            msp_pkg::OFS_MODE:   rd_word = {25'h0000000, mode_reg};
            default: begin
                rd_word = 32'h00000000;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else begin
            if (aw_take) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_got_reg <= 1'b0;
            end
            if (w_take) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_got_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= msp_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_got_reg & ~aw_take & ~s_axi_bvalid;
            s_axi_wready  <= ~w_got_reg & ~w_take & ~s_axi_bvalid;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? msp_pkg::RESP_OKAY : msp_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register; the latch request bit reads back zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_enable_reg <= msp_pkg::CTRL_ENABLE_RST;
            soft_latch_reg  <= 1'b0;
        end else begin
            soft_latch_reg <= do_write & wr_ctrl & wstrb_reg[0] & wdata_reg[1];
            if (do_write && wr_ctrl && wstrb_reg[0]) begin
                ctrl_enable_reg <= wdata_reg[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= msp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? msp_pkg::RESP_OKAY : msp_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// [bench/msp_master_model.sv]
`timescale 1ns/1ps
module msp_master_model (
    input  wire logic aclk,
    input  wire logic sdi,
    output logic      sel_n,
    output logic      sync_dir,
    output logic      sclk,
    output logic      sdo,
    output logic      sdo_oe
);
    // Half of the 160 ns link clock, in aclk cycles
    localparam int HALF = 16;
    initial begin
        sel_n = 1'b1;
        sync_dir = 1'b1;
        sclk = 1'b1;
        sdo = 1'b1;
        sdo_oe = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Pulse held far past two measurement clocks
    task automatic latch();
        sync_dir <= 1'b0;
        step(8);
        sync_dir <= 1'b1;
        step(130);
    endtask
    // No latch here, so a retry sees the old capture
    task automatic begin_read();
        sel_n <= 1'b0;
        step(8);
        sync_dir <= 1'b0;
        step(8);
        sync_dir <= 1'b1;
        step(8);
    endtask
    task automatic begin_write();
        sync_dir <= 1'b0;
        step(8);
        sel_n <= 1'b0;
        step(8);
    endtask
    // Data moves after the trailing edge only
    task automatic send(input logic [7:0] cmd, input int n, input logic drive);
        for (int i = 0; i < n; i++) begin
            sdo <= cmd[7 - i];
            sdo_oe <= drive;
            step(HALF);
            sclk <= 1'b0;
            step(HALF);
            sclk <= 1'b1;
        end
        step(8);
    endtask
    task automatic shift(output logic b);
        step(HALF);
        sclk <= 1'b0;
        b = sdi;
        step(HALF);
        sclk <= 1'b1;
    endtask
    task automatic end_session();
        sdo_oe <= 1'b0;
        sdo <= 1'b1;
        sync_dir <= 1'b1;
        step(8);
        sel_n <= 1'b1;
        step(12);
    endtask
endmodule

// [bench/meter_serial_host_port_asserts.sv]
`timescale 1ns/1ps
module meter_serial_host_port_asserts #(
    parameter int GROUP_W = msp_pkg::GROUP_W
) (
    input wire logic                          aclk,
    input wire logic                          aresetn,
    input wire logic                          s_axi_awvalid,
    input wire logic                          s_axi_awready,
    input wire logic                          s_axi_wvalid,
    input wire logic                          s_axi_wready,
    input wire logic                          s_axi_bvalid,
    input wire logic                          s_axi_arvalid,
    input wire logic                          s_axi_arready,
    input wire logic                          s_axi_rvalid,
    input wire logic                          port_select_n,
    input wire logic                          sync_direction,
    input wire logic                          serial_clock_pin,
    input wire logic                          serial_data_pin_o,
    input wire logic                          serial_data_pin_oe,
    input wire logic [GROUP_W-1:0]            group_ptr_reg,
    input wire logic [msp_pkg::CFG_BITS-1:0]  config_eff_reg,
    input wire logic [msp_pkg::MODE_BITS-1:0] mode_reg
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] idle_cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !port_select_n) begin
            idle_cnt_reg <= 4'h0;
        end else if (idle_cnt_reg != 4'hF) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence write_held;
        (!port_select_n && !sync_direction)[*6];
    endsequence
    sequence read_held;
        (!port_select_n && sync_direction)[*6];
    endsequence
    // Synchroniser latency is far below eight cycles
    sequence pins_quiet;
        ($stable(serial_clock_pin) && $stable(sync_direction) && $stable(port_select_n))[*8];
    endsequence
    write_answer_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    write_drive_off_a: assert property (write_held |-> !serial_data_pin_oe)
        else $error("data driven in write mode");
    idle_drive_off_a: assert property (port_select_n[*6] |-> !serial_data_pin_oe)
        else $error("data driven while deselected");
    read_drive_on_a: assert property (read_held |-> serial_data_pin_oe)
        else $error("data not driven in read mode");
    idle_no_write_a: assert property (idle_cnt_reg == 4'hF |->
        $stable(mode_reg) && $stable(config_eff_reg) && $stable(group_ptr_reg))
        else $error("state changed without a serial clock");
    data_hold_a: assert property (pins_quiet |-> $stable(serial_data_pin_o))
        else $error("data moved without a clock edge");
    group_step_a: assert property ($changed(group_ptr_reg) |->
        group_ptr_reg == GROUP_W'($past(group_ptr_reg) + 1))
        else $error("group pointer jumped");
endmodule
bind meter_serial_host_port meter_serial_host_port_asserts #(.GROUP_W(GROUP_W)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .port_select_n(port_select_n), .sync_direction(sync_direction),
    .serial_clock_pin(serial_clock_pin), .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe(serial_data_pin_oe), .group_ptr_reg(group_ptr_reg),
    .config_eff_reg(config_eff_reg), .mode_reg(mode_reg));

// [bench/meter_serial_host_port_tb.sv]
`timescale 1ns/1ps
module meter_serial_host_port_tb;
    logic         aclk, aresetn, sel_n, syn, sclk, m_d, m_oe, d_o, d_oe, sdi;
    logic [5:0]   awaddr, araddr;
    logic [31:0]  wdata, rdata, d;
    logic [1:0]   bresp, rresp, r;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready;
    logic [255:0] recs;
    logic [3:0]   group_ptr_reg;
    logic [111:0] config_eff_reg;
    logic [6:0]   mode_reg;
    logic [31:0]  exp_rec [8];
    int           fails, checks_done, cyc;
    // Released line floats high through the pull-up
    assign sdi = d_oe ? d_o : (m_oe ? m_d : 1'b1);
    meter_serial_host_port DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_select_n(sel_n), .sync_direction(syn), .serial_clock_pin(sclk),
        .serial_data_pin_i(sdi), .serial_data_pin_o(d_o), .serial_data_pin_oe(d_oe),
        .records_in(recs), .group_ptr_reg(group_ptr_reg), .config_eff_reg(config_eff_reg),
        .mode_reg(mode_reg));
    msp_master_model m (.aclk(aclk), .sdi(sdi), .sel_n(sel_n), .sync_dir(syn), .sclk(sclk),
        .sdo(m_d), .sdo_oe(m_oe));
    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    function automatic logic [31:0] with_par(input logic [27:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int k = 0; k < 7; k++) p ^= v[4 * k +: 4];
        return {p, v};
    endfunction
    // Top nibble junk: the device must replace it
    task automatic fill(input logic [27:0] base, input logic [111:0] cfg);
        for (int i = 0; i < 8; i++) recs[32 * i +: 32] <= {4'hA, base + 28'(i) * 28'h0111111};
        @(posedge aclk);
        for (int i = 0; i < 6; i++) exp_rec[i] = with_par(recs[32 * i +: 28]);
        exp_rec[6] = with_par(cfg[27:0]);
        exp_rec[7] = with_par(cfg[55:28]);
    endtask
    task automatic shift_check(input int nrec, input logic lsbf, input int extra);
        logic b;
        int idx;
        for (int k = 0; k < nrec * 32 + extra; k++) begin
            m.shift(b);
            idx = lsbf ? k % 32 : (k % 32) - 2 * (k % 8) + 7;
            chk("read bit", b, (k < nrec * 32) ? exp_rec[k / 32][idx] : 1'b1);
        end
    endtask
    task automatic cmds(input logic [7:0] c0, input logic [7:0] c1, input logic two);
        m.begin_write();
        m.send(c0, 8, 1'b1);
        if (two) m.send(c1, 8, c1 != 8'hFF);
        chk("drive in write", d_oe, 1'b0);
        m.end_session();
    endtask
    task automatic t_reset();
        chk("group", group_ptr_reg, 0);
        chk("config", config_eff_reg, 0);
        chk("mode", mode_reg, 0);
        chk("drive idle", d_oe, 1'b0);
        axi_rd(msp_pkg::OFS_CTRL, d, r);
        chk("ctrl enable", d[0], msp_pkg::CTRL_ENABLE_RST);
        axi_rd(6'h3C, d, r);
        chk("unmapped read", {rdata, r}, {32'h0, msp_pkg::RESP_SLVERR});
        axi_wr(6'h3C, 32'h0, r);
        chk("unmapped write", r, msp_pkg::RESP_SLVERR);
        axi_wr(msp_pkg::OFS_STATUS, 32'hFFFF_FFFF, r);
        chk("status write", r, msp_pkg::RESP_OKAY);
        $display("reset test done");
    endtask
    task automatic t_writes();
        m.latch();
        m.begin_read();
        shift_check(8, 1'b0, 8);
        m.end_session();
        cmds(8'hFD, 8'h81, 1'b1);
        chk("read disable", mode_reg[msp_pkg::MODE_RD], 1'b1);
        chk("shadow", config_eff_reg, 112'h2);
        m.begin_write();
        m.send(8'h80, 5, 1'b1);
        m.end_session();
        chk("partial cmd", config_eff_reg, 112'h2);
        cmds(8'h85, 8'h0, 1'b0);
        chk("after abort", config_eff_reg, 112'h22);
        $display("read and write test done");
    endtask
    task automatic t_permanent();
        cmds(8'hFE, 8'h87, 1'b1);
        cmds(8'h7E, 8'h07, 1'b1);
        cmds(8'h7D, 8'h0, 1'b0);
        chk("permanent view", config_eff_reg, 112'h80);
        cmds(8'hFD, 8'h0, 1'b0);
        chk("shadow view", config_eff_reg, 112'h22);
        $display("permanent test done");
    endtask
    task automatic t_hold();
        fill(28'h89ABCDE, 112'h22);
        m.latch();
        m.begin_read();
        shift_check(8, 1'b1, 0);
        m.end_session();
        fill(28'h0555555, 112'h22);
        fill(28'h89ABCDE, 112'h22);
        recs[31:0] <= 32'h0;
        m.begin_read();
        shift_check(2, 1'b1, 0);
        m.end_session();
        $display("hold test done");
    endtask
    task automatic t_group_lock();
        cmds(8'hFF, 8'h0, 1'b0);
        m.begin_write();
        m.send(8'hFF, 8, 1'b0);
        m.end_session();
        chk("group", group_ptr_reg, 4'h2);
        cmds(8'h80, 8'h84, 1'b1);
        chk("lock same period", config_eff_reg, 112'h33);
        axi_rd(msp_pkg::OFS_STATUS, d, r);
        chk("status", d[19:12], 8'hA2);
        cmds(8'h86, 8'hFF, 1'b1);
        chk("locked config", config_eff_reg, 112'h33);
        chk("locked advance", group_ptr_reg, 4'h3);
        $display("group and lock test done");
    endtask
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 6'h0;
        araddr = 6'h0;
        wdata = 32'h0;
        fill(28'h0123456, 112'h0);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset();
        t_writes();
        t_permanent();
        t_hold();
        t_group_lock();
        final_report();
    end
endmodule
